// file: src/smbus_pkg.sv
// Package for the two-wire bus controller: register map, field layout, types.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package smbus_pkg;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [7:0] cfg_addr = 8'h00;
   localparam logic [7:0] ctl_addr = 8'h04;
   localparam logic [7:0] dat_addr = 8'h08;

   // ************************************************************
   // Configuration field positions
   // ************************************************************
   localparam int cfg_en_bit = 7;
   localparam int cfg_inh_bit = 6;
   localparam int cfg_busy_bit = 5;
   localparam int cfg_toe_bit = 3;
   localparam int cfg_fte_bit = 2;
   localparam int cfg_cs_lsb = 0;

   // ************************************************************
   // Control field positions
   // ************************************************************
   localparam int ctl_master_bit = 7;
   localparam int ctl_txmode_bit = 6;
   localparam int ctl_sta_bit = 5;
   localparam int ctl_sto_bit = 4;
   localparam int ctl_ackrq_bit = 3;
   localparam int ctl_arblost_bit = 2;
   localparam int ctl_ack_bit = 1;
   localparam int ctl_si_bit = 0;

   localparam logic [7:0] cfg_reset = 8'h00;
   localparam int free_periods = 10;
   localparam logic [1:0] htrans_nonseq = 2'h2;

   typedef enum logic [1:0] {cs_t0, cs_t1, cs_t2h, cs_t2l} clk_src_e;

   typedef enum {
      st_idle, st_start, st_bit_low, st_bit_high, st_ack_low, st_ack_high,
      st_wait_sw, st_stop_low, st_stop_high
   } xfer_e;

   // Pin pair: SCL and SDA input levels
   typedef struct packed {
      logic scl;
      logic sda;
   } pins_s;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
   } ahb_req_s;

endpackage

// file: src/smbus_ctrl.sv
// Two-wire bus master/slave controller with AHB-Lite register access.
// Assumes open-drain pads outside; timer overflow pulses come in on hclk.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - First byte: 7-bit address plus direction
// - Receiver acks by low SDA
// - Start, address, data, then stop
// - Each byte answered by other party
// - Lines only pulled low or released
// - Master start only on free bus
// - Released high read low loses arbitration
// - Master waits for SCL really high
// - Clock low over 25 ms is timeout
// - Timer 3 reloads SCL high, counts low
// - Free after ten source periods high
// - Pending start issued after free timeout
// - Soft ack: interrupt placement by direction
// - Hardware ack: interrupt after ack clock
// - Interrupt on start sent, slave stop
// - Enable bit enables master and slave
// - Inhibit: NACK addresses, no slave interrupts except on received data bytes with soft ack
// - Inhibit takes effect at next start
// - Two-bit field selects overflow source
// - Source used for master, free timeout
// - SCL low, high at least one period
// - Busy set in transfer, cleared stop
module smbus_ctrl
   import smbus_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic hready,
   // Timer overflow pulses
   input wire logic [3:0] tmr_ovf,
   // Companion timer control
   output logic timer3_reload,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   // Event request to software
   output logic smb_irq
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   pins_s meta_ff, sync_ff, prev_ff;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_ff <= '1;
         sync_ff <= '1;
         prev_ff <= '1;
      end
      else
      begin
         meta_ff <= '{scl: scl_in, sda: sda_in};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   logic start_seen, stop_seen, scl_rise;
   assign start_seen = sync_ff.scl && prev_ff.scl && prev_ff.sda && !sync_ff.sda;
   assign stop_seen = sync_ff.scl && prev_ff.scl && !prev_ff.sda && sync_ff.sda;
   assign scl_rise = sync_ff.scl && !prev_ff.scl;

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0] cfg_ff, nxt_cfg;
   logic master_ff, nxt_master;
   logic tx_ff, nxt_tx;
   logic sta_ff, nxt_sta;
   logic sto_ff, nxt_sto;
   logic ackrq_ff, nxt_ackrq;
   logic arblost_ff, nxt_arblost;
   logic ack_ff, nxt_ack;
   logic si_ff, nxt_si;
   logic busy_ff, nxt_busy;
   logic inh_live_ff, nxt_inh_live;
   logic slave_ff, nxt_slave;
   logic addr_ff, nxt_addr;
   logic [7:0] shift_ff, nxt_shift;
   logic [2:0] bit_ff, nxt_bit;
   logic [3:0] free_ff, nxt_free;
   logic [1:0] tick_ff, nxt_tick;
   logic scl_low_ff, nxt_scl_low;
   logic sda_low_ff, nxt_sda_low;
   xfer_e st_ff, nxt_st;
   ahb_req_s req_ff, nxt_req;
   logic [31:0] rdata_ff, nxt_rdata;
   logic reload_ff, nxt_reload;
   logic irq_ff, nxt_irq;

   logic ovf, en, master_wr_ctl;
   logic [7:0] ctl_word;
   assign en = cfg_ff[cfg_en_bit];
   assign ovf = tmr_ovf[cfg_ff[cfg_cs_lsb +: 2]];
   assign ctl_word = {master_ff, tx_ff, sta_ff, sto_ff, ackrq_ff, arblost_ff, ack_ff, si_ff};

   logic take;
   assign take = hsel && hready && htrans == htrans_nonseq;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      nxt_cfg = cfg_ff;
      nxt_master = master_ff;
      nxt_tx = tx_ff;
      nxt_sta = sta_ff;
      nxt_sto = sto_ff;
      nxt_ackrq = ackrq_ff;
      nxt_arblost = arblost_ff;
      nxt_ack = ack_ff;
      nxt_si = si_ff;
      nxt_busy = busy_ff;
      nxt_inh_live = inh_live_ff;
      nxt_slave = slave_ff;
      nxt_addr = addr_ff;
      nxt_shift = shift_ff;
      nxt_bit = bit_ff;
      nxt_free = free_ff;
      nxt_tick = tick_ff;
      nxt_scl_low = scl_low_ff;
      nxt_sda_low = sda_low_ff;
      nxt_st = st_ff;
      nxt_req = req_ff;
      nxt_rdata = rdata_ff;
      master_wr_ctl = 1'b0;

      // Bus slave: one wait-free data phase
      if (take)
      begin
         nxt_req = '{addr: haddr[7:0], write: hwrite};
         if (hwrite)
            nxt_rdata = '0;
         else if (haddr[7:0] == cfg_addr)
            nxt_rdata = {24'h000000, cfg_ff[7:6], busy_ff, cfg_ff[4:0]};
         else if (haddr[7:0] == ctl_addr)
            nxt_rdata = {24'h000000, ctl_word};
         else if (haddr[7:0] == dat_addr)
            nxt_rdata = {24'h000000, shift_ff};
         else
            nxt_rdata = '0;
      end
      else
         nxt_req.write = 1'b0;

      if (req_ff.write)
      begin
         if (req_ff.addr == cfg_addr)
            nxt_cfg = hwdata[7:0];
         else if (req_ff.addr == ctl_addr)
         begin
            master_wr_ctl = 1'b1;
            nxt_sta = hwdata[ctl_sta_bit];
            nxt_sto = hwdata[ctl_sto_bit];
            nxt_ack = hwdata[ctl_ack_bit];
            nxt_arblost = arblost_ff & hwdata[ctl_arblost_bit];
            nxt_si = hwdata[ctl_si_bit] & si_ff;
         end
         else if (req_ff.addr == dat_addr)
            nxt_shift = hwdata[7:0];
      end

      // Free detection on the selected source
      if (!(sync_ff.scl && sync_ff.sda))
         nxt_free = '0;
      else if (cfg_ff[cfg_fte_bit] && ovf && free_ff != 4'(free_periods + 1))
         nxt_free = free_ff + 4'h1;
      // A fresh START outranks a free count left over from just before it
      if (stop_seen || free_ff == 4'(free_periods + 1))
         nxt_busy = 1'b0;
      if (start_seen)
      begin
         nxt_busy = 1'b1;
         nxt_inh_live = cfg_ff[cfg_inh_bit];
      end
      if (ovf)
         nxt_tick = (tick_ff == 2'h3) ? tick_ff : tick_ff + 2'h1;
      // High time counts from the line really going high, not from release
      if (!sync_ff.scl &&
         (st_ff == st_bit_high || st_ff == st_ack_high || st_ff == st_stop_high))
         nxt_tick = '0;

      case (st_ff)
         st_idle:
         begin
            nxt_scl_low = 1'b0;
            nxt_sda_low = 1'b0;
            if (en && sta_ff && !busy_ff && !si_ff)
            begin
               nxt_sda_low = 1'b1;
               nxt_master = 1'b1;
               nxt_tick = '0;
               nxt_st = st_start;
            end
            else if (en && start_seen && !master_ff)
            begin
               nxt_slave = 1'b1;
               nxt_addr = 1'b1;
               nxt_tx = 1'b0;
               nxt_bit = 3'h7;
               nxt_st = st_bit_low;
            end
         end
         st_start:
            if (tick_ff != 2'h0)
            begin
               nxt_scl_low = 1'b1;
               nxt_sta = 1'b0;
               nxt_tx = 1'b1;
               nxt_si = 1'b1;
               nxt_st = st_wait_sw;
            end
         st_wait_sw:
            if (!si_ff && master_wr_ctl == 1'b0)
            begin
               nxt_tick = '0;
               if (master_ff && sto_ff)
               begin
                  nxt_sda_low = 1'b1;
                  nxt_st = st_stop_low;
               end
               else if (ackrq_ff)
               begin
                  nxt_sda_low = master_ff ? !ack_ff : !ack_ff;
                  nxt_st = st_ack_low;
               end
               else
               begin
                  nxt_bit = 3'h7;
                  nxt_sda_low = tx_ff && !shift_ff[7];
                  nxt_st = st_bit_low;
               end
            end
         st_bit_low:
         begin
            if (master_ff && tick_ff != 2'h0)
            begin
               nxt_scl_low = 1'b0;
               nxt_tick = '0;
               nxt_st = st_bit_high;
            end
            else if (!master_ff && scl_rise)
               nxt_st = st_bit_high;
         end
         st_bit_high:
            if (sync_ff.scl && (!master_ff || tick_ff != 2'h0))
            begin
               if (tx_ff && !sda_low_ff && !sync_ff.sda && master_ff)
               begin
                  nxt_arblost = 1'b1;
                  nxt_master = 1'b0;
                  nxt_sda_low = 1'b0;
                  nxt_tx = 1'b0;
                  nxt_slave = 1'b1;
               end
               nxt_shift = {shift_ff[6:0], sync_ff.sda};
               nxt_scl_low = master_ff;
               nxt_tick = '0;
               if (bit_ff == 3'h0)
               begin
                  nxt_sda_low = 1'b0;
                  if (!tx_ff && !(slave_ff && inh_live_ff && addr_ff) && !cfg_ff[cfg_cs_lsb + 1])
                  begin
                     nxt_ackrq = 1'b1;
                     nxt_si = 1'b1;
                     nxt_st = st_wait_sw;
                  end
                  else
                  begin
                     nxt_sda_low = !tx_ff && !(slave_ff && inh_live_ff);
                     nxt_st = st_ack_low;
                  end
               end
               else
               begin
                  nxt_bit = bit_ff - 3'h1;
                  nxt_sda_low = tx_ff && !shift_ff[6];
                  nxt_st = st_bit_low;
               end
            end
            else if (!master_ff && !sync_ff.scl)
               nxt_st = st_bit_low;
         st_ack_low:
            if ((master_ff && tick_ff != 2'h0) || (!master_ff && scl_rise))
            begin
               nxt_scl_low = 1'b0;
               nxt_tick = '0;
               nxt_st = st_ack_high;
            end
         st_ack_high:
            if (sync_ff.scl && (!master_ff || tick_ff != 2'h0))
            begin
               if (tx_ff)
                  nxt_ack = !sync_ff.sda;
               if (slave_ff && addr_ff)
                  nxt_tx = shift_ff[0];
               nxt_addr = 1'b0;
               nxt_ackrq = 1'b0;
               nxt_scl_low = master_ff;
               nxt_sda_low = 1'b0;
               nxt_si = !(slave_ff && inh_live_ff);
               nxt_st = st_wait_sw;
            end
         st_stop_low:
            if (tick_ff != 2'h0)
            begin
               nxt_scl_low = 1'b0;
               nxt_tick = '0;
               nxt_st = st_stop_high;
            end
         st_stop_high:
            if (sync_ff.scl && tick_ff != 2'h0)
            begin
               nxt_sda_low = 1'b0;
               nxt_sto = 1'b0;
               nxt_master = 1'b0;
               nxt_st = st_idle;
            end
         default:
            nxt_st = st_idle;
      endcase

      if (stop_seen && slave_ff)
      begin
         nxt_slave = 1'b0;
         nxt_si = !inh_live_ff;
         nxt_st = st_idle;
      end
      if (!en)
      begin
         nxt_st = st_idle;
         nxt_master = 1'b0;
         nxt_slave = 1'b0;
         nxt_scl_low = 1'b0;
         nxt_sda_low = 1'b0;
      end
      nxt_reload = !(cfg_ff[cfg_toe_bit] && !sync_ff.scl);
      nxt_irq = nxt_si;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_ff <= cfg_reset;
         master_ff <= 1'b0;
         tx_ff <= 1'b0;
         sta_ff <= 1'b0;
         sto_ff <= 1'b0;
         ackrq_ff <= 1'b0;
         arblost_ff <= 1'b0;
         ack_ff <= 1'b0;
         si_ff <= 1'b0;
         busy_ff <= 1'b0;
         inh_live_ff <= 1'b0;
         slave_ff <= 1'b0;
         addr_ff <= 1'b0;
         shift_ff <= '0;
         bit_ff <= '0;
         free_ff <= '0;
         tick_ff <= '0;
         scl_low_ff <= 1'b0;
         sda_low_ff <= 1'b0;
         st_ff <= st_idle;
         req_ff <= '0;
         rdata_ff <= '0;
         reload_ff <= 1'b1;
         irq_ff <= 1'b0;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         master_ff <= nxt_master;
         tx_ff <= nxt_tx;
         sta_ff <= nxt_sta;
         sto_ff <= nxt_sto;
         ackrq_ff <= nxt_ackrq;
         arblost_ff <= nxt_arblost;
         ack_ff <= nxt_ack;
         si_ff <= nxt_si;
         busy_ff <= nxt_busy;
         inh_live_ff <= nxt_inh_live;
         slave_ff <= nxt_slave;
         addr_ff <= nxt_addr;
         shift_ff <= nxt_shift;
         bit_ff <= nxt_bit;
         free_ff <= nxt_free;
         tick_ff <= nxt_tick;
         scl_low_ff <= nxt_scl_low;
         sda_low_ff <= nxt_sda_low;
         st_ff <= nxt_st;
         req_ff <= nxt_req;
         rdata_ff <= nxt_rdata;
         reload_ff <= nxt_reload;
         irq_ff <= nxt_irq;
      end
   end

   // Open-drain: output is always low, only the enable moves
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_low_ff;
   assign sda_oe = sda_low_ff;
   assign hrdata = rdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign timer3_reload = reload_ff;
   assign smb_irq = irq_ff;

endmodule
`default_nettype wire

// file: sim/smbus_ctrl_checker.sv
// Port checker for the two-wire bus controller.
// Assumes the bench drives tmr_ovf pulses and a pulled-up bus.
`timescale 1ns/10ps
`default_nettype none
module smbus_ctrl_checker
   import smbus_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic hready,
   // Line side
   input wire logic [3:0] tmr_ovf,
   input wire logic timer3_reload,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic smb_irq
);
   // ************************************************************
   // Properties
   // ************************************************************
   logic ovf_seen_ff;
   logic nxt_ovf_seen;
   logic rd_take;
   logic bus_take;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign rd_take = hsel && hready && htrans == htrans_nonseq && !hwrite;
   assign bus_take = hsel && hready && htrans == htrans_nonseq;
   // Any overflow counts, so this is a lower bound only
   always_comb nxt_ovf_seen = scl_oe && (ovf_seen_ff || (|tmr_ovf));
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         ovf_seen_ff <= 1'b0;
      else
         ovf_seen_ff <= nxt_ovf_seen;
   a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus response not OKAY or not ready");
   a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("line driven high");
   a_reload_high: assert property (scl_in [*4] |=> timer3_reload)
      else $error("timer not reloaded while clock high");
   a_reload_count: assert property (!timer3_reload |->
      !$past(scl_in, 1) || !$past(scl_in, 2) || !$past(scl_in, 3) || !$past(scl_in, 4))
      else $error("timer counting while clock high");
   a_scl_low_min: assert property ($fell(scl_oe) |-> ovf_seen_ff)
      else $error("clock low shorter than one overflow");
   a_start_hold: assert property ($rose(sda_oe) && !scl_oe && scl_in |-> !scl_oe [*2])
      else $error("clock pulled right after data fell");
   a_stop_order: assert property ($fell(sda_oe) && !scl_oe |->
      !$past(scl_oe, 1) && !$past(scl_oe, 2))
      else $error("data released before clock");
   a_start_event: assert property ($rose(sda_oe) && !scl_oe && scl_in |-> ##[1:200] smb_irq)
      else $error("no event after start");
   // Writes zero the read word too, so any taken transfer may move it
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(bus_take))
      else $error("read data changed without read");
   a_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_unmapped_zero: assert property (rd_take && haddr > {24'h0, dat_addr} |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind smbus_ctrl smbus_ctrl_checker i_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .hready(hready), .tmr_ovf(tmr_ovf), .timer3_reload(timer3_reload),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
   .sda_oe(sda_oe), .smb_irq(smb_irq));
`default_nettype wire

// file: sim/smbus_slave_model.sv
// Slave on the two-wire bus: takes bytes, acks on request, may stretch.
// Assumes resolved line levels with pull-ups; it only ever pulls low.
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Lines
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull,
   // Behaviour control
   input wire logic ack_en,
   input wire logic slow,
   input wire logic hold_low,
   // Seen traffic
   output logic [7:0] rx_byte,
   output int starts,
   output int stops
);
   logic scl_q;
   logic sda_q;
   logic [7:0] sh;
   int bits;
   int str;
   assign scl_pull = hold_low || str != 0;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {scl_q, sda_q, sh, rx_byte} <= '1;
         sda_pull <= 1'b0;
         {bits, str, starts, stops} <= '0;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         if (str != 0)
            str <= str - 1;
         if (scl && scl_q && sda_q && !sda)
         begin
            starts <= starts + 1;
            bits <= 0;
         end
         else if (scl && scl_q && !sda_q && sda)
         begin
            stops <= stops + 1;
            bits <= 0;
         end
         else if (scl && !scl_q && bits < 8)
         begin
            sh <= {sh[6:0], sda};
            bits <= bits + 1;
            if (bits == 7)
               rx_byte <= {sh[6:0], sda};
         end
         else if (!scl && scl_q)
         begin
            if (slow)
               str <= 20;
            if (bits == 8)
            begin
               sda_pull <= ack_en;
               bits <= 9;
            end
            else if (bits == 9)
            begin
               sda_pull <= 1'b0;
               bits <= 0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench: register tasks on AHB-Lite plus line traffic.
// Assumes one slave model on a pulled-up bus and timer pulses from here.
`timescale 1ns/10ps
`default_nettype none
module testbench
   import smbus_pkg::*;
;
   // ************************************************************
   // Signals, design, partner
   // ************************************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] tmr_ovf = 4'h0;
   logic ack_en = 1'b1, slow = 1'b0, hold_low = 1'b0, sda_hold = 1'b0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, timer3_reload, scl_oe, sda_oe, smb_irq;
   logic scl_pull, sda_pull;
   logic [7:0] rx_byte;
   int starts, stops, bad_count = 0, samples_checked = 0, cyc = 0, div = 0, src = 0;
   wire logic scl = !(scl_oe || scl_pull);
   wire logic sda = !(sda_oe || sda_pull || sda_hold);
   always #50 hclk = ~hclk;
   always @(posedge hclk)
   begin
      div <= (div + 1) % 4;
      tmr_ovf <= (div == 3) ? (4'h1 << src) : 4'h0;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         close_out();
      end
   end
   smbus_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout), .tmr_ovf(tmr_ovf),
      .timer3_reload(timer3_reload), .scl_in(scl), .sda_in(sda), .scl_out(),
      .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .smb_irq(smb_irq));
   smbus_slave_model i_slave (.hclk(hclk), .hresetn(hresetn), .scl(scl), .sda(sda),
      .scl_pull(scl_pull), .sda_pull(sda_pull), .ack_en(ack_en), .slow(slow),
      .hold_low(hold_low), .rx_byte(rx_byte), .starts(starts), .stops(stops));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= htrans_nonseq;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   // wait_irq ends 1 ns past an edge so outputs have settled; wait_stop ends on the edge
   task automatic wait_irq();
      int n;
      n = 0;
      // Let a flag cleared at this very edge settle before looking
      #1;
      while (smb_irq !== 1'b1 && n < 3000)
      begin
         @(posedge hclk);
         #1;
         n++;
      end
      chk("event request", 32'h1, {31'h0, smb_irq});
   endtask
   task automatic wait_stop(input int k);
      int n;
      n = 0;
      while (stops < k && n < 3000)
      begin
         @(posedge hclk);
         n++;
      end
      // Busy clears only once the stop has crossed the pin synchroniser
      repeat (3) @(posedge hclk);
      chk("stops on line", 32'(k), 32'(stops));
   endtask
   task automatic send(input logic [7:0] b, input logic ack);
      ack_en <= ack;
      ahb(1'b1, dat_addr, {24'h0, b});
      ahb(1'b1, ctl_addr, 32'h0);
      wait_irq();
      chk("byte on line", {24'h0, b}, {24'h0, rx_byte});
      ahb(1'b0, ctl_addr, 32'h0);
      chk("status", {24'h0, 6'h30, ack, 1'b1}, rd & 32'hC3);
   endtask
   // ************************************************************
   // Tests
   // ************************************************************
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk("config reset", cfg_addr, {24'h0, cfg_reset});
      rchk("control reset", ctl_addr, 32'h0);
      ahb(1'b1, 8'h0C, 32'hFF);
      rchk("unmapped", 8'h0C, 32'h0);
      ahb(1'b1, cfg_addr, 32'h4F);
      rchk("config rw", cfg_addr, 32'h4F);
      ahb(1'b1, cfg_addr, 32'h28);
      rchk("busy read only", cfg_addr, 32'h08);
      $display("test registers done");
      hold_low <= 1'b1;
      repeat (8) @(posedge hclk);
      #1;
      chk("reload while low", 32'h0, {31'h0, timer3_reload});
      hold_low <= 1'b0;
      repeat (8) @(posedge hclk);
      #1;
      chk("reload while high", 32'h1, {31'h0, timer3_reload});
      $display("test companion timer done");
      // Each source code: wrong timer idle, right timer frees bus
      for (int c = 0; c < 4; c++)
      begin
         // Another master opens a transfer and leaves the bus busy
         sda_hold <= 1'b1;
         repeat (4) @(posedge hclk);
         hold_low <= 1'b1;
         repeat (4) @(posedge hclk);
         sda_hold <= 1'b0;
         repeat (4) @(posedge hclk);
         hold_low <= 1'b0;
         src = (c + 1) % 4;
         ahb(1'b1, cfg_addr, 32'h84 | c);
         ahb(1'b1, ctl_addr, 32'h20);
         repeat (120) @(posedge hclk);
         #1;
         chk("no start yet", 32'h0, {31'h0, sda_oe});
         src = c;
         wait_irq();
         chk("starts on line", 32'(2 * c + 2), 32'(starts));
         rchk("busy set", cfg_addr, 32'hA4 | c);
         ahb(1'b0, ctl_addr, 32'h0);
         chk("master event", 32'h81, rd & 32'h81);
         ahb(1'b1, ctl_addr, 32'h10);
         wait_stop(c + 1);
         rchk("busy clear", cfg_addr, 32'h84 | c);
         ahb(1'b1, cfg_addr, 32'h0);
      end
      $display("test clock sources done");
      src = 0;
      ahb(1'b1, cfg_addr, 32'h84);
      ahb(1'b1, ctl_addr, 32'h20);
      wait_irq();
      send(8'hA4, 1'b1);
      slow <= 1'b1;
      send(8'h5B, 1'b1);
      slow <= 1'b0;
      send(8'hC3, 1'b0);
      ahb(1'b1, ctl_addr, 32'h10);
      wait_stop(5);
      rchk("busy after stop", cfg_addr, 32'h84);
      $display("test transfers done");
      close_out();
   end
endmodule
`default_nettype wire
